// file: design/ast_seq.sv
// Purpose: acquisition sequencer with averaging, strobes and acquisition delay
// Assumes: APB slave, synchronous inputs, 20 MHz clock
// Notes: cycle timing counted in microsecond ticks from the trigger event, except the level-trigger integration end, which follows ext_trig
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "ast_map.svh"
// Function
// [R1] averaging runs N integrations, N 2..65535
// [R2] averaging refused with level trigger
// [R3] software request makes the trigger event
// [R4] edge trigger event 20-30 ns after rise; here busy starts one 50 ns clock after the sampled rise
// [R5] fixed 1561 us busy after trigger
// [R6] acquisition delay 0..335500 us, 1 us
// [R7] integration 3800 us to 6 s, 10 us
// [R8] averaged integrations back to back
// [R9] fixed 1553 us busy after last integration
// [R10] two strobes, each separately enabled
// [R11] single strobe low when disabled
// [R12] single strobe rises after programmed delay
// [R13] single strobe high for programmed width
// [R14] single strobe cut at first integration end
// [R15] single strobe ignores acquisition delay
// [R16] continuous strobe 50% duty in integration
// [R17] continuous strobe low when disabled
// [R18] only whole periods under software/edge
// [R19] no pulses unless integration exceeds period
// [R20] level trigger truncates continuous strobe
// [R21] averager sums pixels, divides, truncates
module ast_seq import ast_pkg::*; #(
	parameter logic [15:0] TICK_CYC = 16'(`AST_TICK_CYC),
	parameter logic [23:0] BUSY1_US = 24'(`AST_BUSY1_US),
	parameter logic [23:0] BUSY3_US = 24'(`AST_BUSY3_US)
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_trig,
	input wire logic pix_valid,
	input wire logic [`AST_PIX_W-1:0] pix_idx,
	input wire logic [15:0] pix_data,
	output logic single_strobe,
	output logic cont_strobe,
	output logic acq_busy,
	output logic avg_valid,
	output logic [`AST_PIX_W-1:0] avg_idx,
	output logic [15:0] avg_data
);
	localparam int TRIG_CYC = `AST_TRIG_DLY_CYC;

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a[1:0] == 2'h0) && (a <= `AST_OFF_ICNT);
	endfunction

	logic [1:0] trig_mode_r;
	logic avg_en_r, ss_en_r, cs_en_r, err_r;
	logic [15:0] navg_r;
	logic [18:0] acq_dly_r;
	logic [19:0] integ_r, cs_per_r;
	logic [23:0] ss_dly_r, ss_wid_r;
	logic [31:0] prdata_r, rd_nxt;
	logic wr_en, sw_req, trig_rise, trig_event, start_refused, err_clr, lvl_short;
	ast_state_t state_r;
	logic [23:0] st_us_r, ss_us_r, cs_pos_r;
	logic [15:0] tick_r, int_cnt_r, icnt_done_r;
	logic cyc_avg_r, cyc_lvl_r, trig_prev_r, ss_kill_r, ss_r, cs_r, cs_run_r;
	logic us_tick, int_end, more_int, cyc_done, in_integ;
	logic [23:0] integ_us, per_us, half_us, st_us_inc;
	ast_pix_if pif();

	// apb slave: read data captured in setup, one access cycle
	assign wr_en = psel && penable && pwrite && ce && addr_ok(paddr);
	assign pready = penable && ce;
	assign pslverr = psel && penable && !addr_ok(paddr);
	assign prdata = prdata_r;
	assign sw_req = wr_en && paddr == `AST_OFF_CMD && pwdata[`AST_BIT_START];
	assign err_clr = wr_en && paddr == `AST_OFF_STAT && pwdata[`AST_BIT_ERR];

	always_comb begin
		rd_nxt = 32'h0;
		if (paddr == `AST_OFF_CTRL) begin
			rd_nxt = {27'h0, cs_en_r, ss_en_r, avg_en_r, trig_mode_r};
		end else if (paddr == `AST_OFF_NAVG) begin
			rd_nxt = {16'h0, navg_r};
		end else if (paddr == `AST_OFF_ACQ) begin
			rd_nxt = {13'h0, acq_dly_r};
		end else if (paddr == `AST_OFF_INTEG) begin
			rd_nxt = {12'h0, integ_r};
		end else if (paddr == `AST_OFF_SSDLY) begin
			rd_nxt = {8'h0, ss_dly_r};
		end else if (paddr == `AST_OFF_SSWID) begin
			rd_nxt = {8'h0, ss_wid_r};
		end else if (paddr == `AST_OFF_CSPER) begin
			rd_nxt = {12'h0, cs_per_r};
		end else if (paddr == `AST_OFF_STAT) begin
			rd_nxt = {24'h0, 3'(state_r), err_r, in_integ, cs_r, ss_r, acq_busy};
		end else if (paddr == `AST_OFF_ICNT) begin
			rd_nxt = {16'h0, icnt_done_r};
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			prdata_r <= 32'h0;
		end else if (ce && psel && !penable && !pwrite) begin
			prdata_r <= rd_nxt;
		end
	end

	// configuration writes, out-of-range values clamped
	always_ff @(posedge clk) begin
		if (srst) begin
			trig_mode_r <= 2'h0;
			avg_en_r <= 1'b0;
			ss_en_r <= 1'b0;
			cs_en_r <= 1'b0;
			navg_r <= `AST_RST_NAVG;
			acq_dly_r <= 19'h0;
			integ_r <= `AST_RST_INTEG;
			ss_dly_r <= 24'h0;
			ss_wid_r <= 24'h0;
			cs_per_r <= 20'h0;
		end else if (wr_en) begin
			if (paddr == `AST_OFF_CTRL) begin
				trig_mode_r <= pwdata[1:0];
				avg_en_r <= pwdata[`AST_BIT_AVG];
				ss_en_r <= pwdata[`AST_BIT_SSEN]; // R10
				cs_en_r <= pwdata[`AST_BIT_CSEN]; // R10
			end else if (paddr == `AST_OFF_NAVG) begin
				navg_r <= (pwdata[15:0] < `AST_NAVG_MIN) ? `AST_NAVG_MIN : pwdata[15:0]; // R1
			end else if (paddr == `AST_OFF_ACQ) begin
				acq_dly_r <= (pwdata > {13'h0, `AST_ACQ_MAX_US}) ? `AST_ACQ_MAX_US :
					pwdata[18:0]; // R6
			end else if (paddr == `AST_OFF_INTEG) begin
				if (pwdata < {12'h0, `AST_INTEG_MIN}) begin
					integ_r <= `AST_INTEG_MIN; // R7
				end else if (pwdata > {12'h0, `AST_INTEG_MAX}) begin
					integ_r <= `AST_INTEG_MAX; // R7
				end else begin
					integ_r <= pwdata[19:0];
				end
			end else if (paddr == `AST_OFF_SSDLY) begin
				ss_dly_r <= pwdata[23:0]; // R12
			end else if (paddr == `AST_OFF_SSWID) begin
				ss_wid_r <= pwdata[23:0]; // R13
			end else if (paddr == `AST_OFF_CSPER) begin
				cs_per_r <= pwdata[19:0];
			end
		end
	end

	// trigger selection and event; held off while results drain, a clear would corrupt them
	assign trig_rise = ext_trig && !trig_prev_r;
	assign start_refused = trig_mode_r == TRIG_LEVEL && avg_en_r; // R2
	assign trig_event = ce && state_r == ST_IDLE && !start_refused && !pif.busy &&
		((trig_mode_r != TRIG_EDGE && trig_mode_r != TRIG_LEVEL && sw_req) || // R3
		((trig_mode_r == TRIG_EDGE || trig_mode_r == TRIG_LEVEL) && trig_rise)); // R4

	always_ff @(posedge clk) begin
		if (srst) begin
			trig_prev_r <= 1'b0;
		end else if (ce) begin
			trig_prev_r <= ext_trig;
		end
	end

	// microsecond tick, phase-locked to the trigger event
	always_ff @(posedge clk) begin
		if (srst) begin
			tick_r <= 16'h0;
		end else if (ce) begin
			if (trig_event || state_r == ST_IDLE || us_tick) begin
				tick_r <= 16'h0;
			end else begin
				tick_r <= tick_r + 16'h1;
			end
		end
	end
	assign us_tick = state_r != ST_IDLE && tick_r == TICK_CYC - 16'h1;

	assign integ_us = {4'h0, integ_r} * 24'h00000a;
	assign per_us = {4'h0, cs_per_r} * 24'h00000a;
	assign half_us = {4'h0, cs_per_r} * 24'h000005;
	assign st_us_inc = st_us_r + 24'h1;
	assign in_integ = state_r == ST_INTEG;
	assign int_end = in_integ && (cyc_lvl_r ? !ext_trig : us_tick && st_us_inc == integ_us);
	assign more_int = cyc_avg_r && ({1'b0, int_cnt_r} + 17'h1) < {1'b0, navg_r}; // R1
	assign cyc_done = state_r == ST_BUSY3 && us_tick && st_us_inc == BUSY3_US;
	assign lvl_short = cyc_lvl_r && int_end && st_us_r < `AST_INTEG_MIN_US;

	// acquisition sequencer
	always_ff @(posedge clk) begin
		if (srst) begin
			state_r <= ST_IDLE;
			st_us_r <= 24'h0;
			int_cnt_r <= 16'h0;
			cyc_avg_r <= 1'b0;
			cyc_lvl_r <= 1'b0;
		end else if (ce) begin
			if (us_tick) begin
				st_us_r <= st_us_inc;
			end
			case (state_r)
				ST_IDLE: begin
					if (trig_event) begin
						state_r <= ST_BUSY1; // R5
						st_us_r <= 24'h0;
						int_cnt_r <= 16'h0;
						cyc_avg_r <= avg_en_r;
						cyc_lvl_r <= trig_mode_r == TRIG_LEVEL;
					end
				end
				ST_BUSY1: begin
					if (us_tick && st_us_inc == BUSY1_US) begin
						st_us_r <= 24'h0;
						state_r <= (acq_dly_r == 19'h0) ? ST_INTEG : ST_ACQDLY; // R5
					end
				end
				ST_ACQDLY: begin
					if (us_tick && st_us_inc == {5'h0, acq_dly_r}) begin
						st_us_r <= 24'h0;
						state_r <= ST_INTEG; // R6
					end
				end
				ST_INTEG: begin
					if (int_end) begin
						st_us_r <= 24'h0;
						int_cnt_r <= int_cnt_r + 16'h1;
						state_r <= more_int ? ST_INTEG : ST_BUSY3; // R8
					end
				end
				ST_BUSY3: begin
					if (cyc_done) begin
						st_us_r <= 24'h0;
						state_r <= ST_IDLE; // R9
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// refused start or short level pulse; a new error wins over the clear
	always_ff @(posedge clk) begin
		if (srst) begin
			err_r <= 1'b0;
			icnt_done_r <= 16'h0;
		end else if (ce) begin
			if ((state_r == ST_IDLE && start_refused && (sw_req || trig_rise)) || lvl_short) begin
				err_r <= 1'b1; // R2
			end else if (err_clr) begin
				err_r <= 1'b0;
			end
			if (cyc_done) begin
				icnt_done_r <= int_cnt_r;
			end
		end
	end

	// single strobe, timed from the trigger event only
	always_ff @(posedge clk) begin
		if (srst) begin
			ss_us_r <= 24'h0;
			ss_kill_r <= 1'b0;
			ss_r <= 1'b0;
		end else if (ce) begin
			if (trig_event) begin
				ss_us_r <= 24'h0; // R15
				ss_kill_r <= 1'b0;
			end else if (us_tick && ss_us_r != 24'hffffff) begin
				ss_us_r <= ss_us_r + 24'h1;
			end
			if (int_end) begin
				ss_kill_r <= 1'b1; // R14
			end
			ss_r <= ss_en_r && state_r != ST_IDLE && !ss_kill_r && !int_end && // R11 R14
				ss_us_r >= ss_dly_r && // R12
				({1'b0, ss_us_r} < {1'b0, ss_dly_r} + {1'b0, ss_wid_r}); // R13
		end
	end
	assign single_strobe = ss_r;

	// continuous strobe, restarted at each integration start
	always_ff @(posedge clk) begin
		if (srst) begin
			cs_pos_r <= 24'h0;
			cs_run_r <= 1'b0;
			cs_r <= 1'b0;
		end else if (ce) begin
			if (!in_integ || int_end) begin
				cs_pos_r <= 24'h0;
				cs_run_r <= cs_per_r != 20'h0 && (cyc_lvl_r || integ_us > per_us); // R19
			end else if (us_tick) begin
				if (cs_pos_r == per_us - 24'h1) begin
					cs_pos_r <= 24'h0;
					cs_run_r <= cs_run_r && (cyc_lvl_r || integ_us - st_us_inc >= per_us); // R18
				end else begin
					cs_pos_r <= cs_pos_r + 24'h1;
				end
			end
			cs_r <= cs_en_r && in_integ && !int_end && cs_run_r && // R16 R17 R20
				cs_pos_r < half_us; // R16
		end
	end
	assign cont_strobe = cs_r;
	assign acq_busy = state_r != ST_IDLE;

	// averaging unit hookup
	assign pif.ce = ce;
	assign pif.clear = trig_event;
	assign pif.acc_en = state_r != ST_IDLE && !lvl_short;
	assign pif.pix_valid = pix_valid;
	assign pif.pix_idx = pix_idx;
	assign pif.pix_data = pix_data;
	assign pif.n_div = cyc_avg_r ? navg_r : 16'h0001; // R21
	assign pif.finish = cyc_done;
	assign avg_valid = pif.out_valid;
	assign avg_idx = pif.out_idx;
	assign avg_data = pif.out_data;

	ast_avg u_avg (
		.clk(clk),
		.srst(srst),
		.pif(pif.avg)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_ss_disabled_low: assert property (ce && !ss_en_r |=> !single_strobe) // R11
		else $error("single strobe high while disabled");
	a_cs_disabled_low: assert property (ce && !cs_en_r |=> !cont_strobe) // R17
		else $error("continuous strobe high while disabled");
	a_cs_outside_integ: assert property (!in_integ |-> ##1 !cont_strobe) // R16
		else $error("continuous strobe outside integration");
	a_sw_trig_event: assert property (ce && state_r == ST_IDLE && sw_req && trig_mode_r == TRIG_SW // R3
		&& !avg_en_r && !pif.busy |=> state_r == ST_BUSY1)
		else $error("software request did not start a cycle");
	a_edge_trig_delay: assert property (ce && state_r == ST_IDLE && trig_rise // R4
		&& trig_mode_r == TRIG_EDGE && !pif.busy |-> ##TRIG_CYC state_r == ST_BUSY1)
		else $error("edge trigger event late");
	a_level_avg_refused: assert property (state_r == ST_BUSY1 |-> !(cyc_avg_r && cyc_lvl_r)) // R2
		else $error("averaging started under level trigger");
	a_busy1_length: assert property (state_r == ST_BUSY1 |-> st_us_r < BUSY1_US) // R5
		else $error("initial busy overran");
	a_acq_delay_bound: assert property (state_r == ST_ACQDLY |-> st_us_r < {5'h0, acq_dly_r}) // R6
		else $error("acquisition delay overran");
	a_integ_gap_zero: assert property (ce && int_end && more_int // R8
		|=> in_integ && st_us_r == 24'h0)
		else $error("gap between averaged integrations");
	a_busy3_to_idle: assert property (ce && cyc_done |=> state_r == ST_IDLE && !acq_busy) // R9
		else $error("final busy did not end the cycle");
	a_ss_kill_low: assert property (ss_kill_r && state_r != ST_IDLE |-> ##1 !single_strobe) // R14
		else $error("single strobe after first integration end");
	a_n_range: assert property (state_r == ST_INTEG && cyc_avg_r |-> navg_r >= `AST_NAVG_MIN) // R1
		else $error("averaging count below two");
	a_integ_range: assert property (integ_r >= `AST_INTEG_MIN && integ_r <= `AST_INTEG_MAX) // R7
		else $error("integration setting out of range");

	c_avg_cycle: cover property (cyc_done && cyc_avg_r && int_cnt_r >= 16'h0002);
	c_cs_pulse: cover property ($rose(cont_strobe));
	c_ss_pulse: cover property ($rose(single_strobe) ##[1:100] $fell(single_strobe));
	c_level_cut: cover property (cyc_lvl_r && int_end && cont_strobe);
endmodule
`default_nettype wire

// file: design/ast_map.svh
// Purpose: offsets, field positions, reset values and timing counts of the sequencer
// Assumes: 20 MHz clock, 32-bit APB data, one register per aligned word
// Notes: times are kept in their own unit; cycle counts derive from them
`ifndef AST_MAP_SVH
`define AST_MAP_SVH
`define AST_OFF_CTRL 8'h00
`define AST_OFF_CMD 8'h04
`define AST_OFF_NAVG 8'h08
`define AST_OFF_ACQ 8'h0c
`define AST_OFF_INTEG 8'h10
`define AST_OFF_SSDLY 8'h14
`define AST_OFF_SSWID 8'h18
`define AST_OFF_CSPER 8'h1c
`define AST_OFF_STAT 8'h20
`define AST_OFF_ICNT 8'h24
`define AST_BIT_AVG 2
`define AST_BIT_SSEN 3
`define AST_BIT_CSEN 4
`define AST_BIT_START 0
`define AST_BIT_ERR 4
`define AST_RST_NAVG 16'h0002
`define AST_RST_INTEG 20'h0017c
`define AST_CLK_NS 50
`define AST_US_NS 1000
`define AST_TICK_CYC (`AST_US_NS / `AST_CLK_NS)
`define AST_TRIG_DLY_MIN_NS 20
`define AST_TRIG_DLY_MAX_NS 30
`define AST_TRIG_DLY_CYC ((`AST_TRIG_DLY_MIN_NS + `AST_CLK_NS - 1) / `AST_CLK_NS)
`define AST_BUSY1_US 1561
`define AST_GAP_US 0
`define AST_BUSY3_US 1553
`define AST_ACQ_MAX_US 19'd335500
`define AST_INTEG_MIN 20'd380
`define AST_INTEG_MAX 20'd600000
`define AST_INTEG_MIN_US 24'd3800
`define AST_NAVG_MIN 16'h0002
`define AST_NPIX 8
`define AST_PIX_W 3
`endif

// file: design/ast_pkg.sv
// Purpose: shared types of the acquisition sequencer
// Assumes: nothing beyond the map header
// Notes: enum codes implicit, counting up from zero in order
package ast_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_BUSY1, ST_ACQDLY, ST_INTEG, ST_BUSY3} ast_state_t;
	typedef enum logic [1:0] {TRIG_SW, TRIG_EDGE, TRIG_LEVEL, TRIG_RSVD} ast_trig_t;
endpackage

// file: design/ast_pix_if.sv
// Purpose: carries pixel data and control between sequencer and averager
// Assumes: single clock domain
// Notes: seq drives control and pixels, avg returns results
`timescale 1ns/10ps
`default_nettype none
`include "ast_map.svh"
interface ast_pix_if;
	logic ce;
	logic clear;
	logic acc_en;
	logic pix_valid;
	logic [`AST_PIX_W-1:0] pix_idx;
	logic [15:0] pix_data;
	logic [15:0] n_div;
	logic finish;
	logic busy;
	logic out_valid;
	logic [`AST_PIX_W-1:0] out_idx;
	logic [15:0] out_data;
	modport seq(output ce, clear, acc_en, pix_valid, pix_idx, pix_data, n_div, finish,
		input busy, out_valid, out_idx, out_data);
	modport avg(input ce, clear, acc_en, pix_valid, pix_idx, pix_data, n_div, finish,
		output busy, out_valid, out_idx, out_data);
endinterface
`default_nettype wire

// file: design/ast_avg.sv
// Purpose: per-pixel accumulate over the integrations, then divide by the count
// Assumes: n_div is at least one whenever finish pulses
// Notes: restoring divider, 32 steps per pixel, quotient truncated
`timescale 1ns/10ps
`default_nettype none
`include "ast_map.svh"
module ast_avg import ast_pkg::*; (
	input wire logic clk,
	input wire logic srst,
	ast_pix_if.avg pif
);
	logic [31:0] acc_r [`AST_NPIX];
	logic busy_r, ov_r;
	logic [`AST_PIX_W-1:0] idx_r, oidx_r;
	logic [4:0] step_r;
	logic [16:0] rem_r;
	logic [31:0] dvd_r, quo_r;
	logic [15:0] od_r;
	logic [16:0] rem_sh;
	logic qbit;
	logic [31:0] quo_nxt;

	genvar g;
	for (g = 0; g < `AST_NPIX; g++) begin : g_acc
		always_ff @(posedge clk) begin
			if (srst) begin
				acc_r[g] <= 32'h0;
			end else if (pif.ce) begin
				if (pif.clear) begin
					acc_r[g] <= 32'h0;
				end else if (pif.acc_en && pif.pix_valid && pif.pix_idx == g) begin
					acc_r[g] <= acc_r[g] + {16'h0, pif.pix_data}; // R21
				end
			end
		end
	end

	assign rem_sh = {rem_r[15:0], dvd_r[31]};
	assign qbit = rem_sh >= {1'b0, pif.n_div};
	assign quo_nxt = {quo_r[30:0], qbit};

	// divide sweep, one pixel after another
	always_ff @(posedge clk) begin
		if (srst) begin
			busy_r <= 1'b0;
			idx_r <= '0;
			step_r <= 5'h0;
			rem_r <= 17'h0;
			dvd_r <= 32'h0;
			quo_r <= 32'h0;
			ov_r <= 1'b0;
			oidx_r <= '0;
			od_r <= 16'h0;
		end else if (pif.ce) begin
			ov_r <= 1'b0;
			if (pif.finish && !busy_r) begin
				busy_r <= 1'b1;
				idx_r <= '0;
				step_r <= 5'h0;
				rem_r <= 17'h0;
				dvd_r <= acc_r[0];
			end else if (busy_r) begin
				rem_r <= qbit ? rem_sh - {1'b0, pif.n_div} : rem_sh; // R21
				dvd_r <= {dvd_r[30:0], 1'b0};
				quo_r <= quo_nxt;
				step_r <= step_r + 5'h1;
				if (step_r == 5'h1f) begin
					ov_r <= 1'b1;
					oidx_r <= idx_r;
					od_r <= quo_nxt[15:0];
					rem_r <= 17'h0;
					idx_r <= idx_r + 1'b1;
					dvd_r <= acc_r[idx_r + 1'b1];
					if (idx_r == `AST_PIX_W'(`AST_NPIX - 1)) begin
						busy_r <= 1'b0;
					end
				end
			end
		end
	end

	assign pif.busy = busy_r;
	assign pif.out_valid = ov_r;
	assign pif.out_idx = oidx_r;
	assign pif.out_data = od_r;
endmodule
`default_nettype wire

// file: tb/ast_far.sv
// Purpose: far-side model, trigger source and pixel sample source
// Assumes: driven from the bench through its tasks
// Notes: the idle data line shows the inverted last sample
`timescale 1ns/10ps
`default_nettype none
`include "ast_map.svh"
module ast_far (
	input wire logic clk,
	output logic ext_trig,
	output logic pix_valid,
	output logic [`AST_PIX_W-1:0] pix_idx,
	output logic [15:0] pix_data
);
	initial begin
		ext_trig = 1'b0;
		pix_valid = 1'b0;
		pix_idx = '0;
		pix_data = 16'h0000;
	end
	// high for hi cycles; the release runs on in the background
	task automatic edge_pulse(input int hi);
		@(posedge clk);
		ext_trig <= 1'b1;
		fork
			begin
				repeat (hi) @(posedge clk);
				ext_trig <= 1'b0;
			end
		join_none
	endtask
	task automatic send_batch(input logic [15:0] base, input int gap);
		for (int i = 0; i < `AST_NPIX; i++) begin
			@(posedge clk);
			pix_valid <= 1'b1;
			pix_idx <= i[`AST_PIX_W-1:0];
			pix_data <= base + 16'(i);
			@(posedge clk);
			pix_valid <= 1'b0;
			pix_data <= ~(base + 16'(i));
			repeat (gap) @(posedge clk);
		end
	endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// Purpose: self-checking bench of the acquisition sequencer
// Assumes: shortened tick of 2 cycles per us, short fixed busy times
// Notes: strobe moments are measured from the first busy cycle
`timescale 1ns/10ps
`default_nettype none
`include "ast_map.svh"
module tb;
	localparam int T = 2;
	localparam int B1 = 5;
	localparam int B3 = 5;
	logic clk, srst, ce, psel, penable, pwrite, pready, pslverr, ext_trig;
	logic pix_valid, single_strobe, cont_strobe, acq_busy, avg_valid;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [`AST_PIX_W-1:0] pix_idx, avg_idx;
	logic [15:0] pix_data, avg_data;
	logic [15:0] res [8];
	int errors = 0;
	int checked = 0;
	int n_out, bsy, ss_at, ss_hi, cs_at, cs_n, cs_hi;

	ast_seq #(.TICK_CYC(16'(T)), .BUSY1_US(24'(B1)), .BUSY3_US(24'(B3))) u_ast_seq (
		.clk(clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_trig(ext_trig), .pix_valid(pix_valid), .pix_idx(pix_idx), .pix_data(pix_data),
		.single_strobe(single_strobe), .cont_strobe(cont_strobe), .acq_busy(acq_busy),
		.avg_valid(avg_valid), .avg_idx(avg_idx), .avg_data(avg_data));
	ast_far u_ast_far (.clk(clk), .ext_trig(ext_trig), .pix_valid(pix_valid),
		.pix_idx(pix_idx), .pix_data(pix_data));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		if (avg_valid === 1'b1) begin
			res[avg_idx] <= avg_data;
			n_out <= n_out + 1;
		end
	end

	task automatic summarize();
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic check_rng(input string what, input int got, input int lo, input int hi);
		checked++;
		if (got < lo || got > hi) begin
			errors++;
			$display("[ERR] %0t %s got %0d exp %0d..%0d", $time, what, got, lo, hi);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		check("ready", {31'h0, pready}, 32'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		check(what, q, exp);
	endtask
	task automatic run(input int hold, input int n, input logic [15:0] b1,
		input logic [15:0] b2);
		int w;
		logic [31:0] q;
		logic e;
		logic cs_prev;
		bsy = 0;
		ss_at = -1;
		ss_hi = 0;
		cs_at = -1;
		cs_n = 0;
		cs_hi = 0;
		cs_prev = 1'b0;
		n_out = 0;
		if (hold > 0)
			u_ast_far.edge_pulse(hold);
		else
			apb(1'b1, `AST_OFF_CMD, 32'h1, q, e);
		w = 0;
		while (acq_busy !== 1'b1 && w < 8) begin
			@(posedge clk);
			w++;
		end
		check_rng("trigger to busy", w, 0, 3);
		fork
			while (acq_busy === 1'b1) begin
				bsy++;
				if (single_strobe === 1'b1) begin
					if (ss_at < 0) ss_at = bsy;
					ss_hi++;
				end
				if (cont_strobe === 1'b1) begin
					if (!cs_prev) cs_n++;
					if (cs_at < 0) cs_at = bsy;
					cs_hi++;
				end
				cs_prev = (cont_strobe === 1'b1);
				@(posedge clk);
			end
			begin
				u_ast_far.send_batch(b1, 0);
				if (n > 1) u_ast_far.send_batch(b2, 3);
			end
		join
		w = 0;
		while (n_out < 8 && w < 600) begin
			@(posedge clk);
			w++;
		end
		check("outputs", n_out, 8);
		for (int i = 0; i < 8; i++)
			check("average", {16'h0, res[i]}, (n == 1) ? 32'(b1) + i : (32'(b1) + 32'(b2) + 2 * i) / 2);
	endtask

	task automatic t_regs();
		logic [31:0] q;
		logic e;
		rd_chk("ctrl reset", `AST_OFF_CTRL, 32'h0);
		rd_chk("count reset", `AST_OFF_NAVG, 32'h2);
		rd_chk("integ reset", `AST_OFF_INTEG, 32'h17c);
		wr(`AST_OFF_NAVG, 32'h1);
		rd_chk("count clamp", `AST_OFF_NAVG, 32'h2);
		wr(`AST_OFF_INTEG, 32'ha);
		rd_chk("integ clamp", `AST_OFF_INTEG, 32'h17c);
		wr(`AST_OFF_ACQ, 32'd400000);
		rd_chk("delay clamp", `AST_OFF_ACQ, 32'd335500);
		apb(1'b0, 8'h28, 32'h0, q, e);
		check("unmapped", {31'h0, e}, 32'h1);
		$display("test regs done");
	endtask
	task automatic t_single();
		wr(`AST_OFF_ACQ, 32'h3);
		wr(`AST_OFF_SSDLY, 32'h2);
		wr(`AST_OFF_SSWID, 32'h4);
		wr(`AST_OFF_CSPER, 32'h64);
		wr(`AST_OFF_CTRL, 32'h18);
		run(0, 1, 16'h0100, 16'h0000);
		check("busy", bsy, (B1 + 3 + 3800 + B3) * T);
		check_rng("ss delay", ss_at, 2 * T + 1, 2 * T + 3);
		check("ss width", ss_hi, 4 * T);
		check("cs pulses", cs_n, 3);
		check("cs high", cs_hi, 3 * 500 * T);
		check_rng("cs start", cs_at, (B1 + 3) * T - 1, (B1 + 3) * T + 2);
		$display("test single done");
	endtask
	task automatic t_avg();
		wr(`AST_OFF_ACQ, 32'h0);
		wr(`AST_OFF_SSWID, 32'd50000);
		wr(`AST_OFF_CTRL, 32'h1d);
		run(2, 2, 16'h0064, 16'h00c9);
		check("busy", bsy, (B1 + 7600 + B3) * T);
		check_rng("ss cut", ss_hi, (B1 + 3798) * T - 2, (B1 + 3798) * T + 2);
		check("cs pulses", cs_n, 6);
		rd_chk("integrations", `AST_OFF_ICNT, 32'h2);
		$display("test averaging done");
	endtask
	task automatic t_enables();
		wr(`AST_OFF_SSWID, 32'h4);
		wr(`AST_OFF_CSPER, 32'h17c);
		wr(`AST_OFF_CTRL, 32'h10);
		run(0, 1, 16'h0010, 16'h0000);
		check("ss off", ss_hi, 0);
		check("cs none", cs_n, 0);
		wr(`AST_OFF_CSPER, 32'h64);
		wr(`AST_OFF_CTRL, 32'h08);
		fork
			run(0, 1, 16'h0020, 16'h0000);
			begin
				repeat (100) @(posedge clk);
				ce <= 1'b0;
				repeat (40) @(posedge clk);
				ce <= 1'b1;
			end
		join
		check("busy frozen", bsy, (B1 + 3800 + B3) * T + 40);
		check("cs off", cs_hi, 0);
		check("ss on", ss_hi, 4 * T);
		$display("test enables done");
	endtask
	task automatic t_level();
		logic [31:0] q;
		logic e;
		wr(`AST_OFF_CTRL, 32'h6);
		u_ast_far.edge_pulse(2);
		repeat (10) @(posedge clk);
		check("no start", {31'h0, acq_busy}, 32'h0);
		apb(1'b0, `AST_OFF_STAT, 32'h0, q, e);
		check("error set", {31'h0, q[`AST_BIT_ERR]}, 32'h1);
		wr(`AST_OFF_STAT, 32'h10);
		apb(1'b0, `AST_OFF_STAT, 32'h0, q, e);
		check("error clear", {31'h0, q[`AST_BIT_ERR]}, 32'h0);
		wr(`AST_OFF_CTRL, 32'h12);
		run((B1 + 4300) * T, 1, 16'h0030, 16'h0000);
		check_rng("level busy", bsy, (B1 + 4300 + B3) * T - 1, (B1 + 4300 + B3) * T + 1);
		check("level cs pulses", cs_n, 5);
		check_rng("level cs cut", cs_hi, (4 * 500 + 300) * T - 2, (4 * 500 + 300) * T);
		wr(`AST_OFF_CTRL, 32'h0);
		$display("test level done");
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		$display("[ERR] %0t watchdog expired", $time);
		summarize();
	end
	initial begin
		srst = 1'b1;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_out = 0;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		t_regs();
		t_single();
		t_avg();
		t_enables();
		t_level();
		summarize();
	end
endmodule
`default_nettype wire
